// ===== core/dtil_pkg.sv
/*
  Constants, encodings and timing counts for the drive terminal input logic.
  Assumes a single 125 MHz clock and contact pins that read low when closed.
*/
package dtil_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int STEP_US = 10000;
  localparam int STEP_CYC = STEP_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // ****************************************
  // Contact vector positions
  // ****************************************
  localparam int NUM_CONTACTS = 5;
  localparam int POS_A = 0;
  localparam int POS_B = 1;
  localparam int POS_C = 2;
  localparam int POS_STOP = 3;
  localparam int POS_START = 4;

  // ****************************************
  // Select input functions
  // ****************************************
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_VOLT = 4'h1, FN_CURRENT = 4'h2, FN_PRESET = 4'h3,
    FN_JOG_FWD = 4'h4, FN_JOG_REV = 4'h5, FN_DEC = 4'h6, FN_INC = 4'h7,
    FN_START_REV = 4'h8, FN_RUN_REV = 4'h9
  } dtil_func_t;

  // ****************************************
  // Speed reference sources
  // ****************************************
  typedef enum logic [2:0] {
    REF_KEYPAD = 3'h0, REF_MAN_VOLT = 3'h1, REF_VOLT = 3'h2,
    REF_CURRENT = 3'h3, REF_PRESET1 = 3'h4, REF_PRESET2 = 3'h5,
    REF_PRESET3 = 3'h6, REF_PRESET4 = 3'h7
  } dtil_ref_t;

  // ****************************************
  // Status output choices
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN_IND = 3'h0, ST_FAULT = 3'h1, ST_NFAULT = 3'h2, ST_LOCK = 3'h3,
    ST_AT_SPEED = 3'h4, ST_ABOVE3 = 3'h5, ST_ILIMIT = 3'h6, ST_AUTOMAN = 3'h7
  } dtil_stat_t;

  // ****************************************
  // Control source and rotation settings
  // ****************************************
  localparam logic [1:0] CTL_LOCAL = 2'h0;
  localparam logic [1:0] CTL_REMOTE = 2'h1;
  localparam logic [1:0] CTL_BOTH = 2'h2;
  localparam logic [1:0] ROT_BIDIR = 2'h2;

  // ****************************************
  // Run state machine
  // ****************************************
  typedef enum logic [1:0] {
    RS_STOP = 2'b00, RS_RUN = 2'b01, RS_JOG = 2'b10, RS_TURN = 2'b11
  } dtil_run_t;

  // ****************************************
  // Setpoint and analog scaling
  // ****************************************
  localparam int SP_W = 16;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] SP_MAX = 16'hFFFF;
  localparam int AO_W = 10;
  localparam logic [9:0] AO_OFFSET = 10'h0CD;
  localparam logic [9:0] AO_SPAN = 10'h333;

endpackage : dtil_pkg

// ===== core/dtil_contact_if.sv
/*
  Debounced contact levels passed from the debouncer to the decoder.
  Assumes both ends share ref_clk; a bit is 1 while its contact is closed.
*/
`timescale 1ns/10ps
interface dtil_contact_if;
  logic [4:0] closed;
  modport src (output closed);
  modport dst (input closed);
endinterface : dtil_contact_if

// ===== core/dtil_debounce.sv
/*
  Two-stage synchroniser and per-contact debounce counter.
  Assumes pins read low when closed to common; hold time is a parameter.
*/
`timescale 1ns/10ps
module dtil_debounce import dtil_pkg::*; #(
  parameter int HOLD_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Raw pins, low when closed
  input wire logic [4:0] pin_b,
  // Clean levels
  dtil_contact_if.src out
);
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] level;
  logic [CNT_W-1:0] cnt [NUM_CONTACTS];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
    end else begin
      sync1 <= pin_b;
      sync2 <= sync1;
    end
  end

  // A change must stand for the whole hold time before it is believed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 5'h00;
      for (int i = 0; i < NUM_CONTACTS; i++) cnt[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_CONTACTS; i++) begin
        if (level[i] == !sync2[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] >= CNT_W'(HOLD_CYC - 1)) begin
          cnt[i] <= '0;
          level[i] <= !sync2[i];
        end else begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end

  assign out.closed = level;

endmodule : dtil_debounce

// ===== core/dtil_setpoint.sv
/*
  Raise/lower setpoint: steps once per interval while a request is held.
  Assumes requests are clean levels on ref_clk; lower wins over raise.
*/
`timescale 1ns/10ps
module dtil_setpoint import dtil_pkg::*; #(
  parameter int STEP_INT = STEP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Requests
  input wire logic raise,
  input wire logic lower,
  // Result
  output logic [SP_W-1:0] setpoint
);
  logic [CNT_W-1:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == CNT_W'(STEP_INT - 1));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) tick_cnt <= '0;
    else if (!(raise || lower) || tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      setpoint <= SP_RESET;
    end else if (tick && lower && setpoint != SP_RESET) begin
      setpoint <= setpoint - 1'b1;
    end else if (tick && raise && !lower && setpoint != SP_MAX) begin
      setpoint <= setpoint + 1'b1;
    end
  end

endmodule : dtil_setpoint

// ===== core/dtil_top.sv
/*
  Terminal decoding for the drive: run/stop/jog/direction, reference select,
  raise/lower setpoint, analog output scaling and status contacts.
  Assumes keypad strobes and drive status are on ref_clk; pins are not.
*/
`timescale 1ns/10ps
module dtil_top import dtil_pkg::*; #(
  parameter int HOLD_CYC = DEBOUNCE_CYC,
  parameter int STEP_INT = STEP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Terminal pins, low while closed to common
  input wire logic select_input_a_b,
  input wire logic select_input_b_b,
  input wire logic select_input_c_b,
  input wire logic stop_contact_input_b,
  input wire logic start_forward_input_b,
  // Configuration
  input wire logic [1:0] control_source,
  input wire logic three_wire,
  input wire logic [1:0] rotation_setting,
  input wire logic manual_source,
  input wire logic [3:0] input_a_function,
  input wire logic [3:0] input_b_function,
  input wire logic [3:0] input_c_function_setting,
  input wire logic [2:0] relay_function,
  input wire logic [2:0] collector_one_function,
  input wire logic [2:0] collector_two_function,
  input wire logic freq_offset_span,
  input wire logic load_offset_span,
  // Keypad strobes
  input wire logic keypad_start,
  input wire logic keypad_stop,
  // Drive status
  input wire logic fault_active,
  input wire logic fault_lockout,
  input wire logic at_speed,
  input wire logic above_preset_three,
  input wire logic current_limit,
  input wire logic zero_frequency,
  input wire logic [9:0] output_frequency,
  input wire logic [9:0] output_load,
  // Commands
  output logic run_cmd,
  output logic reverse_cmd,
  output logic jog_cmd,
  output logic decel_to_zero,
  output logic [2:0] ref_source,
  output logic auto_mode,
  output logic [15:0] speed_setpoint,
  // Terminal outputs
  output logic [9:0] frequency_analog_output,
  output logic [9:0] load_analog_output,
  output logic relay_contact_one,
  output logic relay_contact_two,
  output logic collector_output_one,
  output logic collector_output_two
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_ref(input logic [3:0] f);
    is_ref = (f == FN_VOLT) || (f == FN_CURRENT) || (f == FN_PRESET);
  endfunction : is_ref

  function automatic logic [2:0] ref_of(input logic [3:0] f,
                                        input logic [2:0] preset);
    case (f)
      FN_VOLT: ref_of = REF_VOLT;
      FN_CURRENT: ref_of = REF_CURRENT;
      default: ref_of = preset;
    endcase
  endfunction : ref_of

  function automatic logic status_of(input logic [2:0] sel,
                                     input logic running);
    case (sel)
      ST_RUN_IND: status_of = running;
      ST_FAULT: status_of = fault_active;
      ST_NFAULT: status_of = !fault_active;
      ST_LOCK: status_of = fault_lockout;
      ST_AT_SPEED: status_of = at_speed;
      ST_ABOVE3: status_of = above_preset_three;
      ST_ILIMIT: status_of = current_limit;
      default: status_of = auto_mode;
    endcase
  endfunction : status_of

  // Offset span maps 0..1023 onto 2..10 of a 10 unit scale
  function automatic logic [9:0] scale(input logic [9:0] v,
                                       input logic offset);
    logic [19:0] prod;
    prod = v * AO_SPAN;
    scale = offset ? AO_OFFSET + prod[19:10] : v;
  endfunction : scale

  // ****************************************
  // Contact conditioning
  // ****************************************
  dtil_contact_if contacts ();
  logic [4:0] closed;

  dtil_debounce #(.HOLD_CYC(HOLD_CYC)) u_debounce (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_b({start_forward_input_b, stop_contact_input_b, select_input_c_b,
            select_input_b_b, select_input_a_b}),
    .out(contacts.src)
  );
  assign closed = contacts.closed;

  logic a_cl;
  logic b_cl;
  logic c_cl;
  logic stop_cl;
  logic start_cl;
  assign a_cl = closed[POS_A];
  assign b_cl = closed[POS_B];
  assign c_cl = closed[POS_C];
  assign stop_cl = closed[POS_STOP];
  assign start_cl = closed[POS_START];

  // ****************************************
  // Start/stop decode
  // ****************************************
  logic remote;
  logic c_rev;
  logic run_rev;
  logic fwd_req;
  logic rev_req;
  logic jog_req;
  logic term_start;
  logic term_stop;
  logic dir_change;

  // Local-select terminals are not modelled, so BOTH acts as remote
  assign remote = (control_source == CTL_REMOTE) ||
                  (control_source == CTL_BOTH);
  assign run_rev = (input_c_function_setting == FN_RUN_REV);
  assign c_rev = run_rev || (input_c_function_setting == FN_START_REV);
  assign fwd_req = start_cl;
  assign rev_req = c_cl && c_rev &&
                   (rotation_setting == ROT_BIDIR);
  assign jog_req = b_cl && ((input_b_function == FN_JOG_FWD) ||
                            (input_b_function == FN_JOG_REV));

  // Run-reverse takes the stop input out of the loop
  always_comb begin
    if (three_wire && !run_rev) begin
      term_start = (fwd_req || rev_req) && stop_cl;
      term_stop = !stop_cl;
    end else begin
      term_start = (fwd_req || rev_req) && (stop_cl || run_rev);
      term_stop = !term_start;
    end
  end

  assign dir_change = reverse_cmd ? (fwd_req && !rev_req)
                                  : (rev_req && !fwd_req);

  // ****************************************
  // Run state machine
  // ****************************************
  dtil_run_t state;
  dtil_run_t next_state;
  logic next_rev;

  always_comb begin
    next_state = state;
    next_rev = reverse_cmd;
    case (state)
      RS_STOP: begin
        if (remote && jog_req) begin
          next_state = RS_JOG;
          next_rev = (input_b_function == FN_JOG_REV);
        end else if (remote ? term_start : keypad_start) begin
          next_state = RS_RUN;
          next_rev = remote && rev_req && !fwd_req;
        end
      end
      RS_RUN: begin
        if (remote ? term_stop : keypad_stop) next_state = RS_STOP;
        else if (remote && dir_change) next_state = RS_TURN;
      end
      RS_TURN: begin
        if (remote ? term_stop : keypad_stop) begin
          next_state = RS_STOP;
        end else if (zero_frequency) begin
          next_state = RS_RUN;
          next_rev = !reverse_cmd;
        end
      end
      RS_JOG: begin
        if (!b_cl) next_state = RS_STOP;
      end
      default: next_state = RS_STOP;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RS_STOP;
      run_cmd <= 1'b0;
      reverse_cmd <= 1'b0;
      jog_cmd <= 1'b0;
      decel_to_zero <= 1'b0;
    end else begin
      state <= next_state;
      run_cmd <= (next_state != RS_STOP);
      reverse_cmd <= next_rev;
      jog_cmd <= (next_state == RS_JOG);
      decel_to_zero <= (next_state == RS_TURN);
    end
  end

  // ****************************************
  // Speed reference selection
  // ****************************************
  logic [2:0] next_ref;
  logic next_auto;
  logic [1:0] presets_closed;

  always_comb begin
    presets_closed = 2'(a_cl && input_a_function == FN_PRESET) +
                     2'(b_cl && input_b_function == FN_PRESET) +
                     2'(c_cl && input_c_function_setting == FN_PRESET);
    next_auto = 1'b1;
    if (jog_cmd) begin
      next_ref = REF_PRESET2;
    end else if (presets_closed >= 2'h2) begin
      next_ref = REF_PRESET4;
    end else if (c_cl && is_ref(input_c_function_setting)) begin
      next_ref = ref_of(input_c_function_setting, REF_PRESET3);
    end else if (b_cl && is_ref(input_b_function)) begin
      next_ref = ref_of(input_b_function, REF_PRESET2);
    end else if (a_cl && is_ref(input_a_function)) begin
      next_ref = ref_of(input_a_function, REF_PRESET1);
    end else begin
      next_auto = 1'b0;
      next_ref = manual_source ? REF_MAN_VOLT : REF_KEYPAD;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_source <= REF_KEYPAD;
      auto_mode <= 1'b0;
    end else begin
      ref_source <= next_ref;
      auto_mode <= next_auto;
    end
  end

  // ****************************************
  // Raise/lower setpoint
  // ****************************************
  logic sp_lower;
  logic sp_raise;
  logic [15:0] sp_value;
  assign sp_lower = a_cl && (input_a_function == FN_DEC);
  assign sp_raise = b_cl && (input_b_function == FN_INC) && run_cmd;

  dtil_setpoint #(.STEP_INT(STEP_INT)) u_setpoint (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raise(sp_raise),
    .lower(sp_lower),
    .setpoint(sp_value)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) speed_setpoint <= SP_RESET;
    else speed_setpoint <= sp_value;
  end

  // ****************************************
  // Analog and status outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frequency_analog_output <= '0;
      load_analog_output <= '0;
    end else begin
      frequency_analog_output <= scale(output_frequency,
                                       freq_offset_span);
      load_analog_output <= scale(output_load, load_offset_span);
    end
  end

  // Form C pair: both contacts follow the one relay choice
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      relay_contact_one <= 1'b0;
      relay_contact_two <= 1'b1;
      collector_output_one <= 1'b0;
      collector_output_two <= 1'b0;
    end else begin
      relay_contact_one <= status_of(relay_function, run_cmd);
      relay_contact_two <= !status_of(relay_function, run_cmd);
      collector_output_one <= status_of(collector_one_function,
                                        run_cmd);
      collector_output_two <= status_of(collector_two_function,
                                        run_cmd);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_jog_needs_remote_stop;
    $rose(jog_cmd) |-> $past(state) == RS_STOP && $past(remote);
  endproperty
  a_jog_needs_remote_stop: assert property (p_jog_needs_remote_stop)
    else $error("jog entered outside remote stop");

  property p_jog_ref_preset2;
    jog_cmd |=> ref_source == REF_PRESET2;
  endproperty
  a_jog_ref_preset2: assert property (p_jog_ref_preset2)
    else $error("jog not on preset two");

  property p_jog_ignores_keypad;
    state == RS_JOG && b_cl && keypad_stop |=> jog_cmd;
  endproperty
  a_jog_ignores_keypad: assert property (p_jog_ignores_keypad)
    else $error("jog ended while input b closed");

  property p_two_presets;
    presets_closed >= 2'h2 && !jog_cmd |=> ref_source == REF_PRESET4;
  endproperty
  a_two_presets: assert property (p_two_presets)
    else $error("two presets did not pick preset four");

  property p_manual_fallback;
    !next_auto |=> !auto_mode && (ref_source == REF_KEYPAD ||
                                  ref_source == REF_MAN_VOLT);
  endproperty
  a_manual_fallback: assert property (p_manual_fallback)
    else $error("manual fallback missing");

  property p_turn_waits_zero;
    state == RS_TURN && !zero_frequency |=> reverse_cmd == $past(reverse_cmd);
  endproperty
  a_turn_waits_zero: assert property (p_turn_waits_zero)
    else $error("direction flipped before zero frequency");

  property p_local_ignores_terminals;
    state == RS_STOP && !remote && !keypad_start |=> !run_cmd;
  endproperty
  a_local_ignores_terminals: assert property (p_local_ignores_terminals)
    else $error("terminal start honoured in local mode");

  property p_two_wire_stop;
    remote && !three_wire && !run_rev && !stop_cl && state == RS_RUN
      |=> !run_cmd ##1 !run_cmd;
  endproperty
  a_two_wire_stop: assert property (p_two_wire_stop)
    else $error("two-wire run survived open stop contact");

  property p_relay_pair;
    relay_contact_one != relay_contact_two;
  endproperty
  a_relay_pair: assert property (p_relay_pair)
    else $error("relay contacts not complementary");

endmodule : dtil_top

// ===== verification/dtil_contact_model.sv
/*
  Model of the switches and contacts that close the terminal pins.
  Assumes the bench asks for contact states; chatter only when asked.
*/
`timescale 1ns/10ps
module dtil_contact_model (
  // Clock
  input wire logic ref_clk,
  // Requested states, 1 = closed to common
  input wire logic [4:0] want,
  input wire logic chatter,
  // Pins, low while closed
  output logic [4:0] pin_b
);
  initial pin_b = 5'h1F;
  // Chatter flips every cycle, never steady for a full hold time
  always @(negedge ref_clk) begin
    if (chatter)
      pin_b <= ~pin_b;
    else
      pin_b <= ~want;
  end
endmodule : dtil_contact_model

// ===== verification/dtil_top_tb.sv
/*
  Self-checking bench for the drive terminal input logic.
  Assumes short debounce and step counts; pins come from the contact model.
*/
`timescale 1ns/10ps
module dtil_top_tb import dtil_pkg::*;;
  localparam int HOLD = 4;
  localparam int SETTLE = HOLD + 6;
  logic ref_clk, rst_b, chatter, three_wire, manual_source, keypad_start;
  logic keypad_stop, freq_offset_span, load_offset_span, fault_active;
  logic fault_lockout, at_speed, above_preset_three, current_limit;
  logic zero_frequency, run_cmd, reverse_cmd, jog_cmd, decel_to_zero;
  logic auto_mode, relay_contact_one, relay_contact_two;
  logic collector_output_one, collector_output_two;
  logic [1:0] control_source, rotation_setting;
  logic [3:0] input_a_function, input_b_function, input_c_function_setting;
  logic [2:0] relay_function, collector_one_function, collector_two_function;
  logic [2:0] ref_source;
  logic [9:0] output_frequency, output_load;
  logic [9:0] frequency_analog_output, load_analog_output;
  logic [15:0] speed_setpoint;
  logic [4:0] want, pin_b;
  logic [7:0] sv;
  logic [19:0] q[$];
  logic [19:0] nt;
  logic [15:0] obs [13];
  int n_errors = 0;
  int check_count = 0;
  event chk_ev;
  string nm [13] = '{"run", "rev", "jog", "decel", "ref", "auto", "setpoint",
    "freq_ao", "load_ao", "relay", "col1", "col2", "sp_nonzero"};

  dtil_contact_model u_dtil_contact_model (.ref_clk, .want, .chatter, .pin_b);
  dtil_top #(.HOLD_CYC(HOLD), .STEP_INT(3)) u_dtil_top (
    .ref_clk, .rst_b, .select_input_a_b(pin_b[0]), .select_input_b_b(pin_b[1]),
    .select_input_c_b(pin_b[2]), .stop_contact_input_b(pin_b[3]),
    .start_forward_input_b(pin_b[4]), .control_source, .three_wire,
    .rotation_setting, .manual_source, .input_a_function, .input_b_function,
    .input_c_function_setting, .relay_function, .collector_one_function,
    .collector_two_function, .freq_offset_span, .load_offset_span,
    .keypad_start, .keypad_stop, .fault_active, .fault_lockout, .at_speed,
    .above_preset_three, .current_limit, .zero_frequency, .output_frequency,
    .output_load, .run_cmd, .reverse_cmd, .jog_cmd, .decel_to_zero,
    .ref_source, .auto_mode, .speed_setpoint, .frequency_analog_output,
    .load_analog_output, .relay_contact_one, .relay_contact_two,
    .collector_output_one, .collector_output_two);

  always_comb obs = '{16'(run_cmd), 16'(reverse_cmd), 16'(jog_cmd),
    16'(decel_to_zero), 16'(ref_source), 16'(auto_mode), speed_setpoint,
    16'(frequency_analog_output), 16'(load_analog_output),
    16'({relay_contact_one, relay_contact_two}), 16'(collector_output_one),
    16'(collector_output_two), 16'(|speed_setpoint)};

  // **********
  // Checking
  // **********
  task automatic check(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic expect_v(input logic [3:0] k, input logic [15:0] v);
    q.push_back({k, v});
    -> chk_ev;
  endtask : expect_v

  initial forever begin
    @(chk_ev);
    while (q.size() > 0) begin
      nt = q.pop_front();
      check(nm[nt[19:16]], obs[nt[19:16]], nt[15:0]);
    end
  end

  task automatic report_and_stop;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // Offset span squeezes the full range into the upper four fifths
  function automatic logic [9:0] ao(input logic [9:0] v, input logic off);
    logic [19:0] p;
    p = 20'(v) * 20'(AO_SPAN);
    return off ? AO_OFFSET + p[19:10] : v;
  endfunction : ao

  // **********
  // Stimulus
  // **********
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : step

  task automatic contacts(input logic [4:0] w);
    want = w;
    step(SETTLE);
  endtask : contacts

  task automatic pulse_key(input logic st);
    keypad_start = st;
    keypad_stop = !st;
    step(1);
    {keypad_start, keypad_stop} = 2'h0;
    step(2);
  endtask : pulse_key

  task automatic ref_case(input logic [3:0] fa, fb, fc,
                          input logic [4:0] w, input logic [2:0] r);
    input_a_function = fa;
    input_b_function = fb;
    input_c_function_setting = fc;
    contacts(w | 5'h18);
    expect_v(4'h0, 16'h0001);
    expect_v(4'h4, 16'(r));
    expect_v(4'h5, 16'(r > 3'h1));
  endtask : ref_case

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (6000) @(posedge ref_clk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    void'($urandom(85140));
    rst_b = 1'h0;
    want = 5'h00;
    {chatter, three_wire, manual_source, keypad_start, keypad_stop} = 5'h00;
    {freq_offset_span, load_offset_span, zero_frequency} = 3'h0;
    {fault_active, fault_lockout, at_speed} = 3'h0;
    {above_preset_three, current_limit} = 2'h0;
    {output_frequency, output_load} = 20'h00000;
    control_source = CTL_REMOTE;
    rotation_setting = ROT_BIDIR;
    {input_a_function, input_b_function, input_c_function_setting} = 12'h000;
    {relay_function, collector_one_function, collector_two_function} = 9'h000;
    step(2);
    rst_b = 1'h1;
    step(1);
    expect_v(4'h0, 16'h0000);
    expect_v(4'h9, 16'h0001);
    ref_case(FN_NONE, FN_NONE, FN_NONE, 5'h00, REF_KEYPAD);
    manual_source = 1'h1;
    ref_case(FN_NONE, FN_NONE, FN_NONE, 5'h00, REF_MAN_VOLT);
    ref_case(FN_VOLT, FN_NONE, FN_NONE, 5'h01, REF_VOLT);
    ref_case(FN_NONE, FN_CURRENT, FN_NONE, 5'h02, REF_CURRENT);
    ref_case(FN_NONE, FN_NONE, FN_CURRENT, 5'h04, REF_CURRENT);
    ref_case(FN_PRESET, FN_PRESET, FN_PRESET, 5'h01, REF_PRESET1);
    ref_case(FN_PRESET, FN_PRESET, FN_PRESET, 5'h02, REF_PRESET2);
    ref_case(FN_PRESET, FN_PRESET, FN_PRESET, 5'h04, REF_PRESET3);
    ref_case(FN_PRESET, FN_PRESET, FN_PRESET, 5'h03, REF_PRESET4);
    ref_case(FN_PRESET, FN_PRESET, FN_PRESET, 5'h05, REF_PRESET4);
    ref_case(FN_PRESET, FN_PRESET, FN_PRESET, 5'h06, REF_PRESET4);
    ref_case(FN_VOLT, FN_NONE, FN_PRESET, 5'h05, REF_PRESET3);
    ref_case(FN_VOLT, FN_CURRENT, FN_NONE, 5'h03, REF_CURRENT);
    ref_case(FN_CURRENT, FN_VOLT, FN_VOLT, 5'h07, REF_VOLT);
    contacts(5'h10);
    expect_v(4'h0, 16'h0000);
    contacts(5'h00);
    control_source = CTL_LOCAL;
    contacts(5'h18);
    expect_v(4'h0, 16'h0000);
    pulse_key(1'h1);
    expect_v(4'h0, 16'h0001);
    pulse_key(1'h0);
    expect_v(4'h0, 16'h0000);
    three_wire = 1'h1;
    contacts(5'h08);
    control_source = CTL_REMOTE;
    step(2);
    expect_v(4'h0, 16'h0000);
    contacts(5'h18);
    contacts(5'h08);
    expect_v(4'h0, 16'h0001);
    contacts(5'h00);
    contacts(5'h08);
    expect_v(4'h0, 16'h0000);
    three_wire = 1'h0;
    contacts(5'h00);
    {input_a_function, input_c_function_setting} = 8'h00;
    for (int i = 0; i < 2; i++) begin
      input_b_function = i ? FN_JOG_REV : FN_JOG_FWD;
      contacts(5'h02);
      expect_v(4'h2, 16'h0001);
      expect_v(4'h1, 16'(i));
      expect_v(4'h4, 16'(REF_PRESET2));
      pulse_key(1'h0);
      expect_v(4'h0, 16'h0001);
      contacts(5'h00);
      expect_v(4'h0, 16'h0000);
    end
    contacts(5'h18);
    contacts(5'h1A);
    expect_v(4'h2, 16'h0000);
    contacts(5'h00);
    control_source = CTL_LOCAL;
    contacts(5'h02);
    expect_v(4'h2, 16'h0000);
    contacts(5'h00);
    control_source = CTL_BOTH;
    input_b_function = FN_NONE;
    input_c_function_setting = FN_START_REV;
    rotation_setting = 2'h0;
    contacts(5'h0C);
    expect_v(4'h0, 16'h0000);
    contacts(5'h18);
    rotation_setting = ROT_BIDIR;
    contacts(5'h0C);
    expect_v(4'h3, 16'h0001);
    expect_v(4'h1, 16'h0000);
    zero_frequency = 1'h1;
    step(2);
    expect_v(4'h1, 16'h0001);
    expect_v(4'h3, 16'h0000);
    zero_frequency = 1'h0;
    contacts(5'h00);
    input_c_function_setting = FN_RUN_REV;
    contacts(5'h04);
    expect_v(4'h0, 16'h0001);
    contacts(5'h00);
    expect_v(4'h0, 16'h0000);
    input_c_function_setting = FN_NONE;
    input_a_function = FN_DEC;
    input_b_function = FN_INC;
    contacts(5'h02);
    step(30);
    expect_v(4'h6, 16'h0000);
    contacts(5'h18);
    contacts(5'h1A);
    step(30);
    expect_v(4'hC, 16'h0001);
    contacts(5'h01);
    step(90);
    expect_v(4'h6, 16'h0000);
    contacts(5'h00);
    chatter = 1'h1;
    step(20);
    chatter = 1'h0;
    step(SETTLE);
    expect_v(4'h0, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      {fault_active, fault_lockout, at_speed, above_preset_three,
       current_limit} = 5'($urandom);
      output_frequency = 10'($urandom);
      output_load = 10'($urandom);
      {freq_offset_span, load_offset_span} = 2'(k);
      relay_function = 3'(k);
      collector_one_function = 3'(k);
      collector_two_function = 3'(7 - k);
      step(3);
      sv = {1'h0, current_limit, above_preset_three, at_speed,
            fault_lockout, !fault_active, fault_active, 1'h0};
      expect_v(4'h9, 16'({sv[k], !sv[k]}));
      expect_v(4'hA, 16'(sv[k]));
      expect_v(4'hB, 16'(sv[7 - k]));
      expect_v(4'h7, 16'(ao(output_frequency, freq_offset_span)));
      expect_v(4'h8, 16'(ao(output_load, load_offset_span)));
    end
    step(2);
    report_and_stop;
  end
endmodule : dtil_top_tb
